// ---- common/smh_pkg.sv ----
// Package of constants and types for the servo mode and homing control block
package smh_pkg;
    // Operating mode selector codes (signed 8 bit)
    localparam logic [7:0] MODE_PROFILE_VEL   = 8'h03;
    localparam logic [7:0] MODE_TORQUE        = 8'h04;
    localparam logic [7:0] MODE_HOMING        = 8'h06;
    localparam logic [7:0] MODE_POS_HELD_VEL  = 8'h8F; // -113
    localparam logic [7:0] MODE_ANALOG_VEL    = 8'h91; // -111
    localparam logic [7:0] MODE_ANALOG_TORQUE = 8'h9B; // -101
    // Homing methods
    localparam logic [7:0] HOME_METHOD_SWITCH_INDEX = 8'h07;
    localparam logic [7:0] HOME_METHOD_PRESET_ONLY  = 8'h23; // 35: preset without motion
    localparam logic [7:0] HOME_METHOD_MECH_STOP    = 8'hFF; // -1
    // Register offsets
    localparam logic [7:0] REG_MODE        = 8'h00;
    localparam logic [7:0] REG_CONTROL     = 8'h04;
    localparam logic [7:0] REG_TARGET_VEL  = 8'h08;
    localparam logic [7:0] REG_TARGET_TRQ  = 8'h0C;
    localparam logic [7:0] REG_BEGIN_SPD   = 8'h10;
    localparam logic [7:0] REG_FINISH_SPD  = 8'h14;
    localparam logic [7:0] REG_TRQ_SLOPE   = 8'h18;
    localparam logic [7:0] REG_HOME_METHOD = 8'h1C;
    localparam logic [7:0] REG_HOME_OFFSET = 8'h20;
    localparam logic [7:0] REG_SWITCH_SPD  = 8'h24;
    localparam logic [7:0] REG_INDEX_SPD   = 8'h28;
    localparam logic [7:0] REG_STATUS      = 8'h2C;
    localparam logic [7:0] REG_POSITION    = 8'h30;
    localparam logic [7:0] REG_IRQ_STATUS  = 8'h34;
    localparam logic [7:0] REG_IRQ_CLEAR   = 8'h38;
    localparam logic [7:0] REG_IRQ_ENABLE  = 8'h3C;
    localparam logic [7:0] REG_DECEL       = 8'h40;
    localparam logic [7:0] REG_FOLLOW_LIM  = 8'h44;
    // Control bits
    localparam int CTRL_ENABLE_BIT  = 0;
    localparam int CTRL_HOME_GO_BIT = 1;
    localparam int CTRL_HVALID_CLR  = 2;
    // Status bits
    localparam int ST_TARGET_REACHED = 0;
    localparam int ST_HOMING_VALID   = 1;
    localparam int ST_HOMING_BUSY    = 2;
    localparam int ST_POWER_ON       = 3;
    localparam int ST_POS_CTRL       = 4;
    localparam int ST_FOLLOW_ERR     = 5;
    localparam int ST_STOPPED        = 6;
    // Interrupt event bits
    localparam int IRQ_HOME_DONE  = 0;
    localparam int IRQ_FOLLOW_ERR = 1;
    localparam int IRQ_TARGET     = 2;
    localparam int IRQ_WIDTH      = 3;
    // Reset values
    localparam logic [31:0] RESET_DECEL      = 32'h0000_0001;
    localparam logic [31:0] RESET_FOLLOW_LIM = 32'h0000_1000;
    // Motion loop update time and its enable count
    localparam int LOOP_PERIOD_NS = 1000;
    localparam int CLK_PERIOD_NS  = 10;
    localparam int LOOP_CYCLES    = LOOP_PERIOD_NS / CLK_PERIOD_NS;
    // Homing sequencer states
    typedef enum logic [2:0] {
        HS_IDLE     = 3'b000,
        HS_SEEK     = 3'b001,
        HS_ON_SW    = 3'b010,
        HS_SEEK_IDX = 3'b011,
        HS_PRESET   = 3'b100
    } smh_home_state_t;
endpackage

// ---- src/smh_mode_ctrl.sv ----
// Operating mode, velocity/torque profiling and homing control of a servo drive
`timescale 1ns/1ps
module smh_mode_ctrl #(
    parameter int DW = 32
) (
    input  wire logic          CORE_CLK_I,
    input  wire logic          RST_I,
    input  wire logic [7:0]    ADDR_I,
    input  wire logic [31:0]   WDATA_I,
    input  wire logic          WR_I,
    input  wire logic          RD_I,
    output logic      [31:0]   RDATA_O,
    input  wire logic [DW-1:0] FILTERED_ANALOG_INPUT_VOLTAGE_I,
    input  wire logic [DW-1:0] FEEDBACK_POSITION_I,
    input  wire logic          INDEX_PULSE_I,
    input  wire logic          HOME_SWITCH_I,
    input  wire logic          POSITIVE_LIMIT_INPUT_I,
    input  wire logic          NEGATIVE_LIMIT_INPUT_I,
    output logic      [DW-1:0] SPEED_DEMAND_O,
    output logic      [DW-1:0] TORQUE_DEMAND_O,
    output logic               POWER_ENABLE_O,
    output logic      [DW-1:0] POSITION_ACTUAL_O,
    output logic               IRQ_O
);

    // ************************************************************
    // Registers and state
    // ************************************************************
    localparam int IRQ_W = smh_pkg::IRQ_WIDTH;
    logic [7:0]                     mode;
    logic                           enable;
    logic signed [DW-1:0]           target_vel;
    logic signed [DW-1:0]           target_trq;
    logic [DW-1:0]                  ramp_begin_speed;
    logic [DW-1:0]                  ramp_finish_speed;
    logic [DW-1:0]                  trq_slope;
    logic [DW-1:0]                  decel;
    logic [DW-1:0]                  follow_lim;
    logic [7:0]                     home_method;
    logic signed [DW-1:0]           home_offset;
    logic [DW-1:0]                  switch_search_speed;
    logic [DW-1:0]                  index_search_speed;
    logic                           homing_valid_flag;
    logic                           home_go;
    logic signed [DW-1:0]           pos_offset;
    logic signed [DW-1:0]           home_pos;
    logic signed [DW-1:0]           speed;
    logic signed [DW-1:0]           torque;
    logic signed [DW-1:0]           cmd_pos;
    logic [IRQ_W-1:0]               irq_status;
    logic [IRQ_W-1:0]               irq_enable;
    logic [15:0]                    loop_cnt;
    logic                           tick;
    logic                           follow_err;
    logic                           home_done;
    logic                           sw_prev;
    smh_pkg::smh_home_state_t       hstate;

    wire wr_ctrl = WR_I && ADDR_I == smh_pkg::REG_CONTROL;
    wire is_vel  = mode == smh_pkg::MODE_PROFILE_VEL || mode == smh_pkg::MODE_POS_HELD_VEL ||
                   mode == smh_pkg::MODE_ANALOG_VEL;
    wire is_trq  = mode == smh_pkg::MODE_TORQUE || mode == smh_pkg::MODE_ANALOG_TORQUE;
    wire auto_en = mode == smh_pkg::MODE_ANALOG_VEL || mode == smh_pkg::MODE_ANALOG_TORQUE;
    wire pos_ctl = mode == smh_pkg::MODE_POS_HELD_VEL;
    wire powered = enable || auto_en;

    // Requested references: analog input replaces the target in analog modes
    wire signed [DW-1:0] vel_ref = (mode == smh_pkg::MODE_ANALOG_VEL) ?
                                   $signed(FILTERED_ANALOG_INPUT_VOLTAGE_I) : target_vel;
    wire signed [DW-1:0] trq_ref = (mode == smh_pkg::MODE_ANALOG_TORQUE) ?
                                   $signed(FILTERED_ANALOG_INPUT_VOLTAGE_I) : target_trq;
    wire [DW-1:0] vel_mag = vel_ref[DW-1] ? DW'(-vel_ref) : vel_ref;
    wire run_ok = vel_mag > ramp_begin_speed && vel_mag > ramp_finish_speed;
    wire signed [DW-1:0] pos_act = $signed(FEEDBACK_POSITION_I) - pos_offset;
    wire signed [DW-1:0] pos_err = cmd_pos - pos_act;
    wire [DW-1:0] err_mag = pos_err[DW-1] ? DW'(-pos_err) : pos_err;
    wire [DW-1:0] spd_mag = speed[DW-1] ? DW'(-speed) : speed;
    wire trq_reached = torque == trq_ref;
    wire vel_reached = speed == (run_ok ? vel_ref : '0);
    wire target_reached = is_trq ? trq_reached : vel_reached;

    // ************************************************************
    // Motion loop enable
    // ************************************************************
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            loop_cnt <= 16'h0000;
            tick     <= 1'b0;
        end else begin
            tick <= loop_cnt == 16'(smh_pkg::LOOP_CYCLES - 1);
            if (loop_cnt == 16'(smh_pkg::LOOP_CYCLES - 1)) begin
                loop_cnt <= 16'h0000;
            end else begin
                loop_cnt <= loop_cnt + 16'h0001;
            end
        end
    end

    // ************************************************************
    // Register writes
    // ************************************************************
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            mode                <= 8'h00;
            enable              <= 1'b0;
            target_vel          <= '0;
            target_trq          <= '0;
            ramp_begin_speed    <= '0;
            ramp_finish_speed   <= '0;
            trq_slope           <= '0;
            decel               <= DW'(smh_pkg::RESET_DECEL);
            follow_lim          <= DW'(smh_pkg::RESET_FOLLOW_LIM);
            home_method         <= 8'h00;
            home_offset         <= '0;
            switch_search_speed <= '0;
            index_search_speed  <= '0;
            irq_enable          <= '0;
        end else if (WR_I) begin
            case (ADDR_I)
                smh_pkg::REG_MODE:        mode                <= WDATA_I[7:0];
                smh_pkg::REG_CONTROL:     enable              <= WDATA_I[smh_pkg::CTRL_ENABLE_BIT];
                smh_pkg::REG_TARGET_VEL:  target_vel          <= DW'(WDATA_I);
                smh_pkg::REG_TARGET_TRQ:  target_trq          <= DW'(WDATA_I);
                smh_pkg::REG_BEGIN_SPD:   ramp_begin_speed    <= DW'(WDATA_I);
                smh_pkg::REG_FINISH_SPD:  ramp_finish_speed   <= DW'(WDATA_I);
                smh_pkg::REG_TRQ_SLOPE:   trq_slope           <= DW'(WDATA_I);
                smh_pkg::REG_HOME_METHOD: home_method         <= WDATA_I[7:0];
                smh_pkg::REG_HOME_OFFSET: home_offset         <= DW'(WDATA_I);
                smh_pkg::REG_SWITCH_SPD:  switch_search_speed <= DW'(WDATA_I);
                smh_pkg::REG_INDEX_SPD:   index_search_speed  <= DW'(WDATA_I);
                smh_pkg::REG_IRQ_ENABLE:  irq_enable          <= WDATA_I[IRQ_W-1:0];
                smh_pkg::REG_DECEL:       decel               <= DW'(WDATA_I);
                smh_pkg::REG_FOLLOW_LIM:  follow_lim          <= DW'(WDATA_I);
                default: ;
            endcase
        end
    end

    // ************************************************************
    // Velocity profile
    // ************************************************************
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            speed   <= '0;
            cmd_pos <= '0;
        end else if (!powered || !(is_vel || hstate != smh_pkg::HS_IDLE)) begin
            speed   <= '0;
            cmd_pos <= pos_act;
        end else if (tick) begin
            if (hstate != smh_pkg::HS_IDLE) begin
                speed <= (hstate == smh_pkg::HS_SEEK) ? $signed(switch_search_speed) :
                         (hstate == smh_pkg::HS_SEEK_IDX || hstate == smh_pkg::HS_ON_SW) ?
                         -$signed(index_search_speed) : '0;
            end else if (run_ok) begin
                speed <= vel_ref;
            end else if (spd_mag > ramp_finish_speed + decel) begin
                speed <= speed[DW-1] ? speed + $signed(decel) : speed - $signed(decel);
            end else begin
                speed <= '0;
            end
            cmd_pos <= cmd_pos + speed;
        end
    end

    // Position-held mode adds the lost position to the speed demand
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            SPEED_DEMAND_O <= '0;
        end else begin
            SPEED_DEMAND_O <= pos_ctl ? DW'(speed + pos_err) : speed;
        end
    end

    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            follow_err <= 1'b0;
        end else begin
            follow_err <= pos_ctl && powered && err_mag > follow_lim;
        end
    end

    // ************************************************************
    // Torque profile
    // ************************************************************
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            torque <= '0;
        end else if (!powered || !is_trq) begin
            torque <= '0;
        end else if (tick) begin
            if (trq_ref > torque + $signed(trq_slope)) begin
                torque <= torque + $signed(trq_slope);
            end else if (trq_ref < torque - $signed(trq_slope)) begin
                torque <= torque - $signed(trq_slope);
            end else begin
                torque <= trq_ref;
            end
        end
    end

    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            TORQUE_DEMAND_O <= '0;
            POWER_ENABLE_O  <= 1'b0;
        end else begin
            TORQUE_DEMAND_O <= torque;
            POWER_ENABLE_O  <= powered;
        end
    end

    // ************************************************************
    // Homing sequencer, same for incremental and absolute feedback
    // ************************************************************
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            home_go <= 1'b0;
        end else begin
            home_go <= wr_ctrl && WDATA_I[smh_pkg::CTRL_HOME_GO_BIT] && mode == smh_pkg::MODE_HOMING;
        end
    end

    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            hstate    <= smh_pkg::HS_IDLE;
            sw_prev   <= 1'b0;
            home_pos  <= '0;
            home_done <= 1'b0;
        end else begin
            sw_prev   <= HOME_SWITCH_I;
            home_done <= 1'b0;
            case (hstate)
                smh_pkg::HS_IDLE: begin
                    if (home_go && powered) begin
                        if (home_method == smh_pkg::HOME_METHOD_PRESET_ONLY) begin
                            home_pos <= pos_act;
                            hstate   <= smh_pkg::HS_PRESET;
                        end else begin
                            hstate <= HOME_SWITCH_I ? smh_pkg::HS_ON_SW : smh_pkg::HS_SEEK;
                        end
                    end
                end
                smh_pkg::HS_SEEK: begin
                    if (HOME_SWITCH_I && !sw_prev) begin
                        hstate <= smh_pkg::HS_ON_SW;
                    end
                end
                smh_pkg::HS_ON_SW: begin
                    if (!HOME_SWITCH_I) begin
                        hstate <= smh_pkg::HS_SEEK_IDX;
                    end
                end
                smh_pkg::HS_SEEK_IDX: begin
                    if (INDEX_PULSE_I) begin
                        home_pos <= pos_act;
                        hstate   <= smh_pkg::HS_PRESET;
                    end
                end
                smh_pkg::HS_PRESET: begin
                    if (spd_mag == '0) begin
                        home_done <= 1'b1;
                        hstate    <= smh_pkg::HS_IDLE;
                    end
                end
                default: hstate <= smh_pkg::HS_IDLE;
            endcase
            if (mode != smh_pkg::MODE_HOMING || !powered) begin
                hstate <= smh_pkg::HS_IDLE;
            end
        end
    end

    // Preset: actual = end - home - offset; home position reads -offset
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            pos_offset <= '0;
        end else if (home_done) begin
            pos_offset <= home_pos + pos_offset + home_offset;
        end
    end

    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            homing_valid_flag <= 1'b0;
        end else if (home_done) begin
            homing_valid_flag <= 1'b1;
        end else if (wr_ctrl && WDATA_I[smh_pkg::CTRL_HVALID_CLR]) begin
            homing_valid_flag <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            POSITION_ACTUAL_O <= '0;
        end else begin
            POSITION_ACTUAL_O <= pos_act;
        end
    end

    // ************************************************************
    // Interrupts and read data
    // ************************************************************
    wire [IRQ_W-1:0] irq_events = {target_reached, follow_err, home_done};
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            irq_status <= '0;
        end else begin
            irq_status <= (irq_status & ~((WR_I && ADDR_I == smh_pkg::REG_IRQ_CLEAR) ?
                          WDATA_I[IRQ_W-1:0] : '0)) | irq_events;
        end
    end
    assign IRQ_O = |(irq_status & irq_enable);

    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            RDATA_O <= 32'h0000_0000;
        end else if (RD_I) begin
            case (ADDR_I)
                smh_pkg::REG_MODE:        RDATA_O <= {24'h000000, mode};
                smh_pkg::REG_CONTROL:     RDATA_O <= {31'h0, enable};
                smh_pkg::REG_TARGET_VEL:  RDATA_O <= 32'(target_vel);
                smh_pkg::REG_TARGET_TRQ:  RDATA_O <= 32'(target_trq);
                smh_pkg::REG_BEGIN_SPD:   RDATA_O <= 32'(ramp_begin_speed);
                smh_pkg::REG_FINISH_SPD:  RDATA_O <= 32'(ramp_finish_speed);
                smh_pkg::REG_TRQ_SLOPE:   RDATA_O <= 32'(trq_slope);
                smh_pkg::REG_HOME_METHOD: RDATA_O <= {24'h000000, home_method};
                smh_pkg::REG_HOME_OFFSET: RDATA_O <= 32'(home_offset);
                smh_pkg::REG_SWITCH_SPD:  RDATA_O <= 32'(switch_search_speed);
                smh_pkg::REG_INDEX_SPD:   RDATA_O <= 32'(index_search_speed);
                smh_pkg::REG_STATUS:      RDATA_O <= {25'h0, spd_mag == '0, follow_err, pos_ctl, powered,
                                                      hstate != smh_pkg::HS_IDLE, homing_valid_flag,
                                                      target_reached};
                smh_pkg::REG_POSITION:    RDATA_O <= 32'(pos_act);
                smh_pkg::REG_IRQ_STATUS:  RDATA_O <= {29'h0, irq_status};
                smh_pkg::REG_IRQ_ENABLE:  RDATA_O <= {29'h0, irq_enable};
                smh_pkg::REG_DECEL:       RDATA_O <= 32'(decel);
                smh_pkg::REG_FOLLOW_LIM:  RDATA_O <= 32'(follow_lim);
                default:                  RDATA_O <= 32'h0000_0000;
            endcase
        end else begin
            RDATA_O <= 32'h0000_0000;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_auto_enable;
        @(posedge CORE_CLK_I) disable iff (RST_I) auto_en |=> POWER_ENABLE_O;
    endproperty
    a_auto_enable: assert property (p_auto_enable) else $error("analog mode not powered");

    property p_no_start_below;
        @(posedge CORE_CLK_I) disable iff (RST_I)
            (is_vel && !run_ok && speed == '0 && hstate == smh_pkg::HS_IDLE) |=> speed == '0;
    endproperty
    a_no_start_below: assert property (p_no_start_below) else $error("motion below thresholds");

    property p_valid_clear;
        @(posedge CORE_CLK_I) disable iff (RST_I)
            (wr_ctrl && WDATA_I[smh_pkg::CTRL_HVALID_CLR] && !home_done) |=> !homing_valid_flag;
    endproperty
    a_valid_clear: assert property (p_valid_clear) else $error("homing valid not cleared");

    property p_preset;
        @(posedge CORE_CLK_I) disable iff (RST_I)
            home_done |=> pos_offset == $past(home_pos) + $past(pos_offset) + $past(home_offset);
    endproperty
    a_preset: assert property (p_preset) else $error("bad position preset");

    property p_trq_zero_off;
        @(posedge CORE_CLK_I) disable iff (RST_I) !is_trq |=> torque == '0;
    endproperty
    a_trq_zero_off: assert property (p_trq_zero_off) else $error("torque outside torque mode");

    property p_index_stop;
        @(posedge CORE_CLK_I) disable iff (RST_I)
            (hstate == smh_pkg::HS_SEEK_IDX && INDEX_PULSE_I && mode == smh_pkg::MODE_HOMING && powered)
            |=> hstate == smh_pkg::HS_PRESET;
    endproperty
    a_index_stop: assert property (p_index_stop) else $error("index not taken");

    property p_follow_only_held;
        @(posedge CORE_CLK_I) disable iff (RST_I) follow_err |-> $past(pos_ctl);
    endproperty
    a_follow_only_held: assert property (p_follow_only_held) else $error("following error in wrong mode");

    property p_irq;
        @(posedge CORE_CLK_I) disable iff (RST_I) home_done && irq_enable[0] |=> IRQ_O;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt missing");

endmodule // smh_mode_ctrl

// ---- testbench/smh_far_side.sv ----
// Far-side model: feedback sensor, home switch, index pulse and limit switches
`timescale 1ns/1ps
module smh_far_side #(
    parameter int DW      = 32,
    parameter int HOME_AT = 4096
) (
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic [DW-1:0] speed_i,
    output logic      [DW-1:0] position_o,
    output logic               index_o,
    output logic               home_o,
    output logic               pos_limit_o,
    output logic               neg_limit_o
);
    // Shaft position integrates the speed demand
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            position_o <= '0;
        end else begin
            position_o <= position_o + speed_i;
        end
    end
    // Home switch and index follow shaft position; limit switches are tied low
    assign home_o      = $signed(position_o) > HOME_AT;
    assign index_o     = (position_o[9:0] == 10'h000) && (speed_i != '0);
    assign pos_limit_o = 1'h0;
    assign neg_limit_o = 1'h0;
endmodule // smh_far_side

// ---- testbench/tb_top.sv ----
// Self-checking testbench of the servo mode and homing control block
`timescale 1ns/1ps
module tb_top;
    logic        clk = 1'h0, rst = 1'h1, wr_s = 1'h0, rd_s = 1'h0, idx, hsw, pl, nl;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, ain = 32'h0, fb, spd, trq, pos, q;
    logic        pwr, irq;
    int          error_cnt = 0, checks_done = 0;
    always #5 clk = ~clk;
    smh_mode_ctrl smh_mode_ctrl_i (.CORE_CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdat), .WR_I(wr_s),
        .RD_I(rd_s), .RDATA_O(rdat), .FILTERED_ANALOG_INPUT_VOLTAGE_I(ain), .FEEDBACK_POSITION_I(fb),
        .INDEX_PULSE_I(idx), .HOME_SWITCH_I(hsw), .POSITIVE_LIMIT_INPUT_I(pl), .NEGATIVE_LIMIT_INPUT_I(nl),
        .SPEED_DEMAND_O(spd), .TORQUE_DEMAND_O(trq), .POWER_ENABLE_O(pwr), .POSITION_ACTUAL_O(pos), .IRQ_O(irq));
    smh_far_side smh_far_side_i (.clk_i(clk), .rst_i(rst), .speed_i(spd), .position_o(fb), .index_o(idx),
        .home_o(hsw), .pos_limit_o(pl), .neg_limit_o(nl));
    // ****************************************
    // Bus tasks and comparison
    // ****************************************
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk) begin addr <= a; wdat <= d; wr_s <= 1'h1; end
        @(posedge clk) wr_s <= 1'h0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk) begin addr <= a; rd_s <= 1'h1; end
        @(posedge clk) rd_s <= 1'h0;
        #1 q = rdat;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic summarize;
        $display("checks=%0d errors=%0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic settle;
        repeat (3 * smh_pkg::LOOP_CYCLES) @(posedge clk);
    endtask
    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'h0;
        rd(smh_pkg::REG_DECEL);      chk(q, smh_pkg::RESET_DECEL);
        rd(smh_pkg::REG_FOLLOW_LIM); chk(q, smh_pkg::RESET_FOLLOW_LIM);
        rd(8'hFC);                   chk(q, 32'h0);
        chk({31'h0, pwr}, 32'h0);
        wr(smh_pkg::REG_BEGIN_SPD, 32'h60); wr(smh_pkg::REG_DECEL, 32'h20);
        @(posedge clk) ain <= 32'h50;
        wr(smh_pkg::REG_MODE, {24'h0, smh_pkg::MODE_ANALOG_VEL}); settle;
        chk({31'h0, pwr}, 32'h1);
        chk(spd, 32'h0);
        wr(smh_pkg::REG_BEGIN_SPD, 32'h40); settle;
        chk(spd, 32'h50);
        wr(smh_pkg::REG_BEGIN_SPD, 32'h60); repeat (smh_pkg::LOOP_CYCLES + 2) @(posedge clk);
        chk({31'h0, spd != 32'h0 && spd < 32'h50}, 32'h1);
        settle; chk(spd, 32'h0);
        @(posedge clk) ain <= 32'h0;
        wr(smh_pkg::REG_MODE, {24'h0, smh_pkg::MODE_ANALOG_TORQUE}); settle;
        chk({31'h0, pwr}, 32'h1);
        wr(smh_pkg::REG_MODE, {24'h0, smh_pkg::MODE_POS_HELD_VEL}); wr(smh_pkg::REG_CONTROL, 32'h1); settle;
        rd(smh_pkg::REG_STATUS); chk({31'h0, q[smh_pkg::ST_POS_CTRL]}, 32'h1);
        wr(smh_pkg::REG_MODE, {24'h0, smh_pkg::MODE_TORQUE}); wr(smh_pkg::REG_CONTROL, 32'h1);
        wr(smh_pkg::REG_TRQ_SLOPE, 32'h40); wr(smh_pkg::REG_TARGET_TRQ, 32'h100);
        repeat (smh_pkg::LOOP_CYCLES) @(posedge clk);
        rd(smh_pkg::REG_STATUS); chk({31'h0, q[smh_pkg::ST_TARGET_REACHED]}, 32'h0);
        settle; chk(trq, 32'h100);
        rd(smh_pkg::REG_STATUS); chk({31'h0, q[smh_pkg::ST_POWER_ON]}, 32'h1);
        chk({31'h0, q[smh_pkg::ST_TARGET_REACHED]}, 32'h1);
        wr(smh_pkg::REG_IRQ_ENABLE, 32'h1);
        wr(smh_pkg::REG_MODE, {24'h0, smh_pkg::MODE_HOMING});
        wr(smh_pkg::REG_HOME_METHOD, {24'h0, smh_pkg::HOME_METHOD_PRESET_ONLY});
        wr(smh_pkg::REG_HOME_OFFSET, 32'h10);
        wr(smh_pkg::REG_CONTROL, 32'h1);
        wr(smh_pkg::REG_CONTROL, 32'h3);
        for (int i = 0; i < 50; i++) begin
            rd(smh_pkg::REG_STATUS);
            if (q[smh_pkg::ST_HOMING_VALID] === 1'h1) break;
            repeat (smh_pkg::LOOP_CYCLES) @(posedge clk);
        end
        chk({31'h0, q[smh_pkg::ST_HOMING_VALID]}, 32'h1);
        chk(spd, 32'h0);
        chk(pos, 32'hFFFF_FFF0);
        chk({31'h0, irq}, 32'h1);
        rd(smh_pkg::REG_IRQ_STATUS); chk({31'h0, q[smh_pkg::IRQ_HOME_DONE]}, 32'h1);
        wr(smh_pkg::REG_IRQ_CLEAR, 32'h1); chk({31'h0, irq}, 32'h0);
        wr(smh_pkg::REG_CONTROL, 32'h5);
        rd(smh_pkg::REG_STATUS); chk({31'h0, q[smh_pkg::ST_HOMING_VALID]}, 32'h0);
        // Switch-and-index homing, no mechanical stop so no torque limit is needed
        wr(smh_pkg::REG_HOME_METHOD, {24'h0, smh_pkg::HOME_METHOD_SWITCH_INDEX});
        wr(smh_pkg::REG_INDEX_SPD, 32'h10);
        wr(smh_pkg::REG_CONTROL, 32'h3);
        repeat (smh_pkg::LOOP_CYCLES + 2) @(posedge clk);
        chk(spd, 32'hFFFF_FFF0);
        for (int i = 0; i < 50; i++) begin
            rd(smh_pkg::REG_STATUS);
            if (q[smh_pkg::ST_HOMING_VALID] === 1'h1) break;
            repeat (smh_pkg::LOOP_CYCLES) @(posedge clk);
        end
        chk({31'h0, q[smh_pkg::ST_HOMING_VALID]}, 32'h1);
        chk(pos, fb - 32'h0000_0C00 - 32'h0000_0010);
        summarize;
    end
    initial begin
        #300000;
        error_cnt++;
        summarize;
    end
endmodule // tb_top
